// ==== design/ijm_defs.vh ====
// Offsets, fields, reset values and timing counts of the indexer jog/mode control
`ifndef IJM_DEFS_VH
`define IJM_DEFS_VH

`define IJM_OFF_OPTYPE 8'h00
`define IJM_OFF_JOGTYPE 8'h04
`define IJM_OFF_DIR 8'h08
`define IJM_OFF_DIVCNT 8'h0C
`define IJM_OFF_TLDELAY 8'h10
`define IJM_OFF_ALTTL 8'h14
`define IJM_OFF_NORMTL 8'h18
`define IJM_OFF_LINKCFG 8'h1C
`define IJM_OFF_STATUS 8'h20
`define IJM_OFF_IRQSTAT 8'h24
`define IJM_OFF_IRQMASK 8'h28

`define IJM_RST_OPTYPE 16'h0000
`define IJM_RST_JOGTYPE 16'h0000
`define IJM_RST_DIR 1'h0
`define IJM_RST_DIVCNT 16'h0002
`define IJM_RST_TLDELAY 16'h0000
`define IJM_RST_ALTTL 16'h0000
`define IJM_RST_NORMTL 16'hFFFF
`define IJM_RST_LINKCFG 2'h0
`define IJM_RST_IRQMASK 5'h00

`define IJM_TOP_DIGIT_MSB 15
`define IJM_TOP_DIGIT_LSB 12
`define IJM_LOW_DIGIT_MSB 3
`define IJM_LOW_DIGIT_LSB 0
`define IJM_OPTYPE_INDEXER 4'h1
`define IJM_JOG_PLAIN 4'h1

`define IJM_LINK_TWO_STATIONS 0
`define IJM_LINK_DIRECT_SPEED 1

`define IJM_IRQ_ACCEPT 0
`define IJM_IRQ_DONE 1
`define IJM_IRQ_IGNORED 2
`define IJM_IRQ_RANGE 3
`define IJM_IRQ_HOME 4
`define IJM_IRQ_W 5

`define IJM_TABLE_ONE 16'h0001
`define IJM_RESP_OKAY 2'h0
`define IJM_RESP_SLVERR 2'h2

`define IJM_CLK_NS 20
`define IJM_TICK_NS 1000000
`define IJM_TICK_CYCLES (`IJM_TICK_NS / `IJM_CLK_NS)

`endif

// ==== design/ijm_hold_delay.v ====
// Level delay: output rises after the arm level has held for a programmed tick count
`timescale 1ns/1ps
module ijm_hold_delay (
  input wire aclk,
  input wire aresetn,
  input wire tick,
  input wire arm,
  input wire [15:0] delay_ticks,
  output reg expired
);
  reg [15:0] count;

  // Dropping the arm level restarts the count, so a short bounce never shortens the delay
  always @(posedge aclk) begin
    if (!aresetn) begin
      count <= 16'h0000;
      expired <= 1'b0;
    end else if (!arm) begin
      count <= 16'h0000;
      expired <= 1'b0;
    end else if (count >= delay_ticks) begin
      expired <= 1'b1;
    end else if (tick) begin
      count <= count + 16'h0001;
    end
  end
endmodule // ijm_hold_delay

// ==== design/ijm_indexer_ctrl.v ====
// Indexer start/jog sequencing, flags, torque limit switch and AXI4-Lite registers
`timescale 1ns/1ps
`include "ijm_defs.vh"
module ijm_indexer_ctrl #(
  parameter TICK_CYCLES = `IJM_TICK_CYCLES
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [7:0] s_axi_araddr,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  input wire start_request_bit,
  input wire mode_select_a,
  input wire mode_select_b,
  input wire [15:0] next_station_word,
  input wire [15:0] table_or_speed_word,
  input wire home_done,
  input wire pos_in_station_range,
  input wire motion_complete,
  output reg movement_done_flag,
  output reg in_position_flag,
  output reg station_range_warning,
  output reg home_incomplete_alarm,
  output reg cmd_start,
  output reg cmd_positioning,
  output reg [15:0] cmd_station,
  output reg [15:0] cmd_table,
  output reg cmd_direct_speed,
  output reg [15:0] cmd_speed,
  output reg jog_run,
  output reg jog_ccw,
  output reg jog_stop_on_station,
  output reg [15:0] torque_limit,
  output wire irq
);
  localparam ST_IDLE = 2'd0;
  localparam ST_MOVE = 2'd1;
  localparam ST_JOG = 2'd2;
  localparam ST_STOP = 2'd3;

  reg [15:0] optype;
  reg [15:0] jogtype;
  reg dir_ccw;
  reg [15:0] divcnt;
  reg [15:0] tl_delay;
  reg [15:0] alt_tl;
  reg [15:0] norm_tl;
  reg [1:0] link_cfg;
  reg [4:0] irq_mask;
  reg [4:0] irq_stat;
  reg [4:0] next_irq_stat;

  reg aw_hold;
  reg w_hold;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  reg [1:0] state;
  reg start_q;
  reg [15:0] tick_cnt;
  reg tick;
  wire tl_expired;

  // Byte-lane merge of a write into a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge16[7:0] = strb[0] ? data[7:0] : old[7:0];
      merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
  endfunction

  function is_mapped;
    input [7:0] addr;
    begin
      case (addr)
        `IJM_OFF_OPTYPE, `IJM_OFF_JOGTYPE, `IJM_OFF_DIR, `IJM_OFF_DIVCNT,
        `IJM_OFF_TLDELAY, `IJM_OFF_ALTTL, `IJM_OFF_NORMTL, `IJM_OFF_LINKCFG,
        `IJM_OFF_STATUS, `IJM_OFF_IRQSTAT, `IJM_OFF_IRQMASK: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // Write channel: address and data are taken in either order
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  wire do_wr = aw_hold && w_hold && !s_axi_bvalid;
  wire wr_hit = do_wr && is_mapped(aw_addr_q);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IJM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `IJM_RESP_OKAY : `IJM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      optype <= `IJM_RST_OPTYPE;
      jogtype <= `IJM_RST_JOGTYPE;
      dir_ccw <= `IJM_RST_DIR;
      divcnt <= `IJM_RST_DIVCNT;
      tl_delay <= `IJM_RST_TLDELAY;
      alt_tl <= `IJM_RST_ALTTL;
      norm_tl <= `IJM_RST_NORMTL;
      link_cfg <= `IJM_RST_LINKCFG;
      irq_mask <= `IJM_RST_IRQMASK;
    end else if (wr_hit) begin
      case (aw_addr_q)
        `IJM_OFF_OPTYPE: optype <= merge16(optype, w_data_q, w_strb_q);
        `IJM_OFF_JOGTYPE: jogtype <= merge16(jogtype, w_data_q, w_strb_q);
        `IJM_OFF_DIVCNT: divcnt <= merge16(divcnt, w_data_q, w_strb_q);
        `IJM_OFF_TLDELAY: tl_delay <= merge16(tl_delay, w_data_q, w_strb_q);
        `IJM_OFF_ALTTL: alt_tl <= merge16(alt_tl, w_data_q, w_strb_q);
        `IJM_OFF_NORMTL: norm_tl <= merge16(norm_tl, w_data_q, w_strb_q);
        `IJM_OFF_DIR: dir_ccw <= w_strb_q[0] ? w_data_q[0] : dir_ccw;
        `IJM_OFF_LINKCFG: link_cfg <= w_strb_q[0] ? w_data_q[1:0] : link_cfg;
        `IJM_OFF_IRQMASK: irq_mask <= w_strb_q[0] ? w_data_q[4:0] : irq_mask;
        default: begin
        end
      endcase
    end
  end

  // Read channel: one read at a time, answer one cycle after the address
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `IJM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? `IJM_RESP_OKAY : `IJM_RESP_SLVERR;
      case (s_axi_araddr)
        `IJM_OFF_OPTYPE: s_axi_rdata <= {16'h0000, optype};
        `IJM_OFF_JOGTYPE: s_axi_rdata <= {16'h0000, jogtype};
        `IJM_OFF_DIR: s_axi_rdata <= {31'h00000000, dir_ccw};
        `IJM_OFF_DIVCNT: s_axi_rdata <= {16'h0000, divcnt};
        `IJM_OFF_TLDELAY: s_axi_rdata <= {16'h0000, tl_delay};
        `IJM_OFF_ALTTL: s_axi_rdata <= {16'h0000, alt_tl};
        `IJM_OFF_NORMTL: s_axi_rdata <= {16'h0000, norm_tl};
        `IJM_OFF_LINKCFG: s_axi_rdata <= {30'h00000000, link_cfg};
        `IJM_OFF_STATUS: s_axi_rdata <= {24'h000000, tl_expired, state,
          home_incomplete_alarm, station_range_warning, in_position_flag,
          movement_done_flag, jog_run};
        `IJM_OFF_IRQSTAT: s_axi_rdata <= {27'h0000000, irq_stat};
        `IJM_OFF_IRQMASK: s_axi_rdata <= {27'h0000000, irq_mask};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Millisecond tick for the torque limit delay
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES[15:0] - 16'h0001) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // Mode decode
  wire indexer_on = optype[`IJM_TOP_DIGIT_MSB:`IJM_TOP_DIGIT_LSB] == `IJM_OPTYPE_INDEXER;
  wire auto_mode = indexer_on && mode_select_a && mode_select_b;
  wire manual_mode = indexer_on && mode_select_a && !mode_select_b;
  wire plain_jog = jogtype[`IJM_LOW_DIGIT_MSB:`IJM_LOW_DIGIT_LSB] == `IJM_JOG_PLAIN;
  // Compared as station+1 > count so a zero count cannot underflow
  wire range_bad = ({1'b0, next_station_word} + 17'h00001) > {1'b0, divcnt};
  wire direct_ok = link_cfg[`IJM_LINK_TWO_STATIONS] && link_cfg[`IJM_LINK_DIRECT_SPEED];

  wire start_rise = start_request_bit && !start_q;
  wire start_fall = !start_request_bit && start_q;
  wire start_usable = start_rise && (auto_mode || manual_mode);
  wire start_busy = start_usable && (state != ST_IDLE);
  wire start_nohome = start_usable && (state == ST_IDLE) && !home_done;
  wire start_ok = start_usable && (state == ST_IDLE) && home_done
    && (manual_mode || !range_bad);
  wire range_rise = auto_mode && range_bad && !station_range_warning;
  wire done_evt = motion_complete && (state == ST_MOVE || state == ST_STOP);

  always @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= 1'b0;
      state <= ST_IDLE;
      movement_done_flag <= 1'b1;
      cmd_start <= 1'b0;
      cmd_positioning <= 1'b0;
      cmd_station <= 16'h0000;
      cmd_table <= `IJM_TABLE_ONE;
      cmd_direct_speed <= 1'b0;
      cmd_speed <= 16'h0000;
      jog_run <= 1'b0;
      jog_ccw <= 1'b0;
      jog_stop_on_station <= 1'b0;
    end else begin
      start_q <= start_request_bit;
      cmd_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_ok) begin
            movement_done_flag <= 1'b0;
            cmd_start <= 1'b1;
            if (manual_mode) begin
              // Selection words are not looked at in manual mode
              state <= ST_JOG;
              cmd_positioning <= 1'b0;
              cmd_station <= 16'h0000;
              cmd_table <= `IJM_TABLE_ONE;
              cmd_direct_speed <= 1'b0;
              jog_run <= 1'b1;
              jog_ccw <= dir_ccw;
              jog_stop_on_station <= !plain_jog;
            end else begin
              state <= ST_MOVE;
              cmd_positioning <= 1'b1;
              cmd_station <= next_station_word;
              cmd_direct_speed <= direct_ok;
              cmd_table <= direct_ok ? `IJM_TABLE_ONE : table_or_speed_word;
              cmd_speed <= table_or_speed_word;
            end
          end
        end
        ST_MOVE: begin
          if (motion_complete) begin
            state <= ST_IDLE;
            cmd_positioning <= 1'b0;
            movement_done_flag <= 1'b1;
          end
        end
        ST_JOG: begin
          // Leaving manual mode mid-jog is treated like a release
          if (start_fall || !manual_mode) begin
            state <= ST_STOP;
            jog_run <= 1'b0;
          end
        end
        ST_STOP: begin
          if (motion_complete) begin
            state <= ST_IDLE;
            jog_stop_on_station <= 1'b0;
            movement_done_flag <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      station_range_warning <= 1'b0;
      home_incomplete_alarm <= 1'b0;
      in_position_flag <= 1'b0;
      torque_limit <= `IJM_RST_NORMTL;
      irq_stat <= 5'h00;
    end else begin
      station_range_warning <= auto_mode && range_bad;
      if (start_nohome) begin
        home_incomplete_alarm <= 1'b1;
      end else if (home_done) begin
        home_incomplete_alarm <= 1'b0;
      end
      // Also true straight after reset when parked on a station
      in_position_flag <= (state == ST_IDLE) && pos_in_station_range;
      torque_limit <= tl_expired ? alt_tl : norm_tl;
      irq_stat <= next_irq_stat;
    end
  end

  ijm_hold_delay u_tl_delay (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .arm(in_position_flag),
    .delay_ticks(tl_delay),
    .expired(tl_expired)
  );

  // Sticky event bits; a new event wins over a same-cycle clear
  always @* begin
    next_irq_stat = irq_stat;
    if (wr_hit && aw_addr_q == `IJM_OFF_IRQSTAT && w_strb_q[0]) begin
      next_irq_stat = irq_stat & ~w_data_q[4:0];
    end
    next_irq_stat[`IJM_IRQ_ACCEPT] = next_irq_stat[`IJM_IRQ_ACCEPT] | start_ok;
    next_irq_stat[`IJM_IRQ_DONE] = next_irq_stat[`IJM_IRQ_DONE] | done_evt;
    next_irq_stat[`IJM_IRQ_IGNORED] = next_irq_stat[`IJM_IRQ_IGNORED] | start_busy;
    next_irq_stat[`IJM_IRQ_RANGE] = next_irq_stat[`IJM_IRQ_RANGE] | range_rise;
    next_irq_stat[`IJM_IRQ_HOME] = next_irq_stat[`IJM_IRQ_HOME] | start_nohome;
  end

  assign irq = |(irq_stat & irq_mask);
endmodule // ijm_indexer_ctrl

// ==== test/ijm_chk.sv ====
// Port-level assertions for the indexer jog and mode control
`timescale 1ns/1ps
module ijm_chk (
  input wire aclk,
  input wire aresetn,
  input wire start_request_bit,
  input wire mode_select_a,
  input wire mode_select_b,
  input wire home_done,
  input wire pos_in_station_range,
  input wire motion_complete,
  input wire movement_done_flag,
  input wire in_position_flag,
  input wire cmd_start,
  input wire [15:0] cmd_station,
  input wire [15:0] cmd_table,
  input wire jog_run
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  done_clear_a: assert property (cmd_start |-> !movement_done_flag)
    else $error("done flag high at accept");
  start_edge_a: assert property (cmd_start |-> $past(start_request_bit) &&
    !$past(start_request_bit, 2)) else $error("accept without start rise");
  busy_ignore_a: assert property (cmd_start |-> $past(movement_done_flag))
    else $error("accept while busy");
  home_req_a: assert property (cmd_start |-> $past(home_done))
    else $error("accept before home return");
  jog_stop_a: assert property (jog_run && !start_request_bit |=> !jog_run)
    else $error("jog runs after release");
  jog_hold_a: assert property (jog_run && start_request_bit && mode_select_a &&
    !mode_select_b |=> jog_run) else $error("jog dropped while held");
  in_pos_a: assert property (in_position_flag |-> $past(pos_in_station_range))
    else $error("in-position without range");
  manual_cmd_a: assert property (cmd_start && jog_run |->
    cmd_station == 16'h0000 && cmd_table == 16'h0001) else $error("manual words used");
  done_set_a: assert property (motion_complete && !movement_done_flag &&
    !jog_run |=> movement_done_flag) else $error("done not set");
endmodule // ijm_chk
bind ijm_indexer_ctrl ijm_chk u_ijm_chk (.aclk(aclk), .aresetn(aresetn),
  .start_request_bit(start_request_bit), .mode_select_a(mode_select_a),
  .mode_select_b(mode_select_b), .home_done(home_done),
  .pos_in_station_range(pos_in_station_range), .motion_complete(motion_complete),
  .movement_done_flag(movement_done_flag), .in_position_flag(in_position_flag),
  .cmd_start(cmd_start), .cmd_station(cmd_station), .cmd_table(cmd_table),
  .jog_run(jog_run));

// ==== test/ijm_master.sv ====
// Fieldbus master model that raises and holds the start request level
`timescale 1ns/1ps
module ijm_master (
  input wire aclk,
  input wire aresetn,
  input wire req,
  input wire rude,
  input wire [7:0] hold_cyc,
  input wire movement_done_flag,
  output reg start_request_bit
);
  reg [7:0] cnt;
  always @(posedge aclk) begin
    if (!aresetn) begin
      start_request_bit <= 1'b0;
      cnt <= 8'h00;
    end else if (start_request_bit) begin
      if (cnt == 8'h00)
        start_request_bit <= 1'b0;
      cnt <= cnt - 8'h01;
    end else if (req && (movement_done_flag || rude)) begin
      // Rude start only when a scenario asks for it
      start_request_bit <= 1'b1;
      cnt <= hold_cyc;
    end
  end
endmodule // ijm_master

// ==== test/indexer_jog_mode_control_tb_top.sv ====
// Self-checking bench for the indexer jog and mode control block
`timescale 1ns/1ps
`include "ijm_defs.vh"
module indexer_jog_mode_control_tb_top;
  localparam TK = 4;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  reg [7:0] awa = 8'h00, ara = 8'h00, hold = 8'h04;
  reg [31:0] wd = 32'h0, rd;
  reg req = 1'b0, rude = 1'b0, ma = 1'b0, mb = 1'b0, hd = 1'b0, pin = 1'b0, mc = 1'b0;
  reg [15:0] stn = 16'h0000, tsw = 16'h0000;
  reg [1:0] rs;
  wire awr, wrd, bv, arr, rv, st, dn, inp, wrn, alm, cst, cpo, cds, jr, jccw, jsos, irq;
  wire [1:0] brs, rrs;
  wire [31:0] rdt;
  wire [15:0] cstn, ctab, cspd, tq;
  integer mismatches = 0, checked = 0, cyc = 0, nst = 0, n0, i;
  // Model: stations the rules expect at each accepted start, oldest first
  int exp_q[$];
  ijm_indexer_ctrl #(.TICK_CYCLES(TK)) u_ijm_indexer_ctrl (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_bresp(brs), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdt),
    .s_axi_rresp(rrs), .start_request_bit(st), .mode_select_a(ma), .mode_select_b(mb),
    .next_station_word(stn), .table_or_speed_word(tsw), .home_done(hd),
    .pos_in_station_range(pin), .motion_complete(mc), .movement_done_flag(dn),
    .in_position_flag(inp), .station_range_warning(wrn), .home_incomplete_alarm(alm),
    .cmd_start(cst), .cmd_positioning(cpo), .cmd_station(cstn), .cmd_table(ctab),
    .cmd_direct_speed(cds), .cmd_speed(cspd), .jog_run(jr), .jog_ccw(jccw),
    .jog_stop_on_station(jsos), .torque_limit(tq), .irq(irq));
  ijm_master u_ijm_master (.aclk(aclk), .aresetn(aresetn), .req(req), .rude(rude),
    .hold_cyc(hold), .movement_done_flag(dn), .start_request_bit(st));
  task report_and_stop;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cst === 1'b1)
      nst <= nst + 1;
    if (cst === 1'b1) begin
      chk("model_acc", exp_q.size() > 0, 1);
      if (exp_q.size() > 0)
        chk("model_stn", cstn, exp_q.pop_front());
    end
    if (cyc == 6000) begin
      mismatches = mismatches + 1;
      report_and_stop;
    end
  end
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task step(input integer n);
    repeat (n) @(posedge aclk);
  endtask
  // Ready is sampled just before the edge that takes the channel
  task bus(input w, input [7:0] a, input [31:0] d);
    reg ta, tw, tx, tb, go;
    begin
      awa <= a;
      ara <= a;
      wd <= d;
      awv <= w;
      wv <= w;
      bry <= w;
      arv <= !w;
      rry <= !w;
      go = 1'b1;
      while (go) begin
        @(negedge aclk);
        ta = arv & arr;
        tw = wv & wrd;
        tx = awv & awr;
        tb = w ? bv : rv;
        rd = rdt;
        rs = w ? brs : rrs;
        @(posedge aclk);
        if (ta)
          arv <= 1'b0;
        if (tw)
          wv <= 1'b0;
        if (tx)
          awv <= 1'b0;
        if (tb) begin
          bry <= 1'b0;
          rry <= 1'b0;
        end
        go = !tb;
      end
      @(posedge aclk);
    end
  endtask
  task kick(input [7:0] h, input r);
    begin
      while (st)
        @(posedge aclk);
      hold <= h;
      rude <= r;
      req <= 1'b1;
      @(posedge aclk);
      while (st !== 1'b1)
        @(posedge aclk);
      req <= 1'b0;
    end
  endtask
  task fin;
    begin
      mc <= 1'b1;
      @(posedge aclk);
      mc <= 1'b0;
      step(2);
    end
  endtask
  initial begin
    rd = $urandom(32'hCA6042B1);
    step(16);
    aresetn <= 1'b1;
    step(2);
    chk("done_rst", dn, 1);
    bus(0, `IJM_OFF_DIVCNT, 0);
    chk("div_rst", rd, 2);
    bus(0, 8'h40, 0);
    chk("unmapped", rs, `IJM_RESP_SLVERR);
    bus(1, 8'h40, 32'h1);
    chk("wr_unmapped", rs, `IJM_RESP_SLVERR);
    bus(1, `IJM_OFF_OPTYPE, 32'h1000);
    bus(1, `IJM_OFF_DIVCNT, 32'h8);
    bus(1, `IJM_OFF_IRQMASK, 32'h1F);
    ma <= 1'b1;
    mb <= 1'b1;
    kick(8'h04, 1'b0);
    step(4);
    chk("home_alarm", {alm, dn}, 2'b11);
    chk("home_nomove", nst, 0);
    hd <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      bus(1, `IJM_OFF_LINKCFG, i);
      // Words settle at least one edge ahead of the start edge
      exp_q.push_back($urandom % 7);
      stn <= 16'(exp_q[$]);
      tsw <= 16'($urandom);
      n0 = nst;
      kick(8'h04, 1'b0);
      step(3);
      chk("accept", nst - n0, 1);
      chk("moving", {dn, cpo}, 2'b01);
      chk("station", cstn, stn);
      chk("direct", cds, i == 3);
      chk("table", ctab, (i == 3) ? 16'h0001 : tsw);
      if (i == 3)
        chk("speed", cspd, tsw);
      kick(8'h02, 1'b1);
      step(3);
      chk("busy_ign", nst - n0, 1);
      fin;
      chk("done", dn, 1);
    end
    chk("home_clr", alm, 0);
    bus(1, `IJM_OFF_LINKCFG, 0);
    stn <= 16'h0008;
    n0 = nst;
    kick(8'h04, 1'b0);
    step(3);
    chk("range_warn", wrn, 1);
    chk("range_nomove", nst - n0, 0);
    stn <= 16'h0007;
    step(3);
    chk("range_edge", wrn, 0);
    mb <= 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      bus(1, `IJM_OFF_JOGTYPE, i & 1);
      bus(1, `IJM_OFF_DIR, i >> 1);
      stn <= 16'($urandom);
      exp_q.push_back(0);
      tsw <= 16'($urandom);
      kick(8'h06 + 8'($urandom % 4), 1'b0);
      step(3);
      chk("jog_run", jr, 1);
      chk("jog_dir", jccw, i >> 1);
      chk("jog_stn", jsos, !(i & 1));
      chk("jog_words", {cstn, ctab}, 32'h0000_0001);
      while (st)
        @(posedge aclk);
      step(2);
      chk("jog_rel", {jr, dn}, 2'b00);
      fin;
      chk("jog_done", {dn, jsos}, 2'b10);
    end
    // Losing manual mode while start is still held must end the jog
    exp_q.push_back(0);
    kick(8'h20, 1'b0);
    mb <= 1'b1;
    step(2);
    chk("jog_mode_rel", jr, 0);
    mb <= 1'b0;
    fin;
    chk("jog_mode_done", dn, 1);
    bus(1, `IJM_OFF_OPTYPE, 32'h0FFF);
    n0 = nst;
    kick(8'h02, 1'b0);
    step(3);
    chk("no_indexer", nst - n0, 0);
    bus(1, `IJM_OFF_OPTYPE, 32'h1000);
    ma <= 1'b0;
    kick(8'h02, 1'b0);
    step(3);
    chk("no_mode", nst - n0, 0);
    ma <= 1'b1;
    bus(1, `IJM_OFF_TLDELAY, 2);
    bus(1, `IJM_OFF_ALTTL, 32'h55);
    pin <= 1'b1;
    while (inp !== 1'b1)
      @(posedge aclk);
    n0 = cyc;
    while (tq !== 16'h0055)
      @(posedge aclk);
    chk("tq_delay", (cyc - n0 > TK) && (cyc - n0 < 3 * TK + 4), 1);
    chk("in_pos", inp, 1);
    pin <= 1'b0;
    step(5);
    chk("tq_norm", tq, 16'hFFFF);
    bus(0, `IJM_OFF_IRQSTAT, 0);
    chk("irq_ign", rd[2], 1);
    chk("irq_on", irq, 1);
    bus(1, `IJM_OFF_IRQMASK, 0);
    chk("irq_mask", irq, 0);
    bus(1, `IJM_OFF_IRQMASK, 32'h1F);
    bus(1, `IJM_OFF_IRQSTAT, 32'h1F);
    chk("irq_clr", irq, 0);
    chk("model_left", exp_q.size(), 0);
    report_and_stop;
  end
endmodule // indexer_jog_mode_control_tb_top
